// file: program_sequencer.sv
// Function
// RULE1: Four system clocks per instruction cycle
// RULE2: Fetch next word while current one executes
// RULE3: Counter changes cost one extra dummy cycle
// RULE4: Counter increments after every fetch
// RULE5: Met skip discards fetched word, continues +2
// RULE6: Low byte write jumps within page
// RULE7: Reset clears counter to zero
// RULE8: External interrupt loads its vector
// RULE9: Timer interrupt loads its vector
// RULE10: Program memory 2048 words of 14 bits
// RULE11: Current-page table uses counter upper bits
// RULE12: Last-page table forces upper bits high
// RULE13: Table low byte to memory, rest high
// RULE14: Lookup pointer read/write, loaded before table
// RULE15: Table read takes two cycles
// RULE16: Four hidden stack entries, hidden index
// RULE17: Call and acknowledge push, returns pop
// RULE18: Reset leaves stack empty
// RULE19: Full stack withholds interrupt acknowledge
// RULE20: Call on full stack drops oldest
// RULE21: Unimplemented low locations read zero
// RULE22: General memory 20H to 7FH, read/write
// RULE23: Slot zero reaches pointed location indirectly
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

module program_sequencer
(
    input  wire logic              sys_clk,     // System clock
    input  wire logic              sys_rst,     // Asynchronous reset, active high
    input  wire seq_pkg::reg_req_t reg_req,     // Register bus request
    output logic [7:0]             reg_rdata,   // Read data, cycle after read strobe
    output logic [10:0]            rom_addr,    // Program memory word address
    input  wire logic [13:0]       rom_data,    // Program memory word
    input  wire seq_pkg::seq_cmd_t cmd,         // Sequencing command from decoder
    input  wire logic              ext_irq,     // External request, enabled and pending
    input  wire logic              tmr_irq,     // Timer request, enabled and pending
    output logic                   ext_ack,     // External acknowledge pulse
    output logic                   tmr_ack,     // Timer acknowledge pulse
    output logic                   isr_exit_op_done,   // Interrupt return pulse
    output logic [13:0]            instr_word,  // Instruction in execution
    output logic                   instr_exec,  // Instruction is real, not dummy
    output logic [1:0]             phase,       // Current clock phase
    output logic [10:0]            fetch_pc     // Program counter (fetch address)
);

    // Whole module state
    typedef struct packed {
        logic [1:0]                phase;      // Phase within instruction cycle
        logic [10:0]               pc;         // Fetch address
        logic [10:0]               rom_addr;   // Address held on program memory
        logic [13:0]               instr;      // Latched instruction
        logic                      exec;       // Latched instruction is to execute
        logic                      tab_busy;   // Table read cycle in progress
        logic [7:0]                tab_dest;   // Table low byte destination
        logic                      pcl_pend;   // Low byte write waiting for boundary
        logic [7:0]                pcl_val;    // Pending low byte
        logic [7:0]                dptr;       // Data pointer
        logic [7:0]                tblptr;     // Lookup pointer
        logic [5:0]                tblhi;      // Lookup high byte bits
        logic [3:0][10:0]          stack;      // Return stack entries
        logic [1:0]                sp_wr;      // Next stack slot to write
        logic [2:0]                depth;      // Entries in use
        logic [95:0][7:0]          ram;        // General purpose memory
        logic [7:0]                rdata;      // Read data register
        logic                      ext_ack;    // External acknowledge pulse
        logic                      tmr_ack;    // Timer acknowledge pulse
        logic                      isr_exit_op_done;  // Interrupt return pulse
    } state_t;

    state_t s;       // Registered state
    state_t next_s;  // Next state

    // Decode one data memory location for reading
    function automatic logic [7:0] read_loc(input state_t x, input logic [7:0] a);
        logic [7:0] r;
        r = seq_pkg::ZERO_BYTE;
        if (a == seq_pkg::ADDR_DPTR)
            r = x.dptr;
        else if (a == seq_pkg::ADDR_PCL)
            r = x.pc[7:0];
        else if (a == seq_pkg::ADDR_TBLPTR)
            r = x.tblptr;                                              // RULE14
        else if (a == seq_pkg::ADDR_TBLHI)
            r = {2'h0, x.tblhi};                                       // RULE13
        else if (a >= seq_pkg::ADDR_RAM_LO && a <= seq_pkg::ADDR_RAM_HI)
            r = x.ram[7'(a - seq_pkg::ADDR_RAM_LO)];                   // RULE22
        return r;                                                      // RULE21
    endfunction

    // Write one data memory location; read-only and empty ones ignore it
    function automatic state_t write_loc(input state_t x, input logic [7:0] a,
                                         input logic [7:0] d);
        state_t y;
        y = x;
        if (a == seq_pkg::ADDR_DPTR)
            y.dptr = d;
        else if (a == seq_pkg::ADDR_PCL)
        begin
            y.pcl_pend = 1'b1;
            y.pcl_val  = d;
        end
        else if (a == seq_pkg::ADDR_TBLPTR)
            y.tblptr = d;                                              // RULE14
        else if (a >= seq_pkg::ADDR_RAM_LO && a <= seq_pkg::ADDR_RAM_HI)
            y.ram[7'(a - seq_pkg::ADDR_RAM_LO)] = d;                   // RULE22
        return y;
    endfunction

    // Resolve the indirect slot to the pointed location
    function automatic logic [7:0] resolve(input state_t x, input logic [7:0] a,
                                           output logic void_slot);
        void_slot = 1'b0;
        if (a == seq_pkg::ADDR_INDIRECT)
        begin
            void_slot = (x.dptr == seq_pkg::ADDR_INDIRECT);            // RULE23
            return x.dptr;
        end
        return a;
    endfunction

    // Push a return address, overwriting the oldest when full
    function automatic state_t push(input state_t x, input logic [10:0] ret_pc);
        state_t y;
        y = x;
        y.stack[x.sp_wr] = ret_pc;                                     // RULE17
        y.sp_wr = x.sp_wr + 2'h1;                                      // RULE20
        if (x.depth != seq_pkg::STACK_FULL)                            // RULE16
            y.depth = x.depth + 3'h1;
        return y;
    endfunction

    // Next state logic
    always_comb
    begin
        logic [7:0]  eff_addr;   // Address after indirect resolution
        logic        void_slot;  // Indirect access of the slot itself
        logic [10:0] ret_pc;     // Popped return address
        seq_pkg::seq_op_t op;    // Command of the executing cycle
        eff_addr  = seq_pkg::ZERO_BYTE;
        void_slot = 1'b0;
        ret_pc    = seq_pkg::RESET_VEC;
        op        = seq_pkg::OP_NONE;
        next_s    = s;
        next_s.ext_ack   = 1'b0;
        next_s.tmr_ack   = 1'b0;
        next_s.isr_exit_op_done = 1'b0;
        next_s.rdata     = seq_pkg::ZERO_BYTE;
        next_s.phase     = s.phase + 2'h1;                             // RULE1

        // Register bus read, answered in the next cycle
        if (reg_req.rd)
        begin
            eff_addr = resolve(s, reg_req.addr, void_slot);
            if (!void_slot)
                next_s.rdata = read_loc(s, eff_addr);                  // RULE23
        end

        // Register bus write; indirect write to the slot itself does nothing
        if (reg_req.wr)
        begin
            eff_addr = resolve(s, reg_req.addr, void_slot);
            if (!void_slot)
                next_s = write_loc(next_s, eff_addr, reg_req.wdata);   // RULE23
        end

        // Instruction cycle boundary
        if (s.phase == seq_pkg::PHASE_LAST)
        begin
            if (s.tab_busy)
            begin
                // Second table cycle: store the word, resume held instruction
                next_s = write_loc(next_s, s.tab_dest, rom_data[7:0]); // RULE13
                next_s.tblhi    = rom_data[13:8];                      // RULE13
                next_s.tab_busy = 1'b0;                                // RULE15
                next_s.exec     = 1'b1;
                next_s.rom_addr = s.pc;
            end
            else
            begin
                // Ordinary fetch overlapped with execution
                next_s.instr = rom_data;                               // RULE2
                next_s.exec  = 1'b1;                                   // RULE2
                next_s.pc    = s.pc + 11'h001;                         // RULE4
                if (s.exec)
                    op = cmd.op;
                if (next_s.pcl_pend)
                begin
                    // Short jump inside the current page
                    next_s.pc       = {s.pc[10:8], next_s.pcl_val};    // RULE6
                    next_s.pcl_pend = 1'b0;
                    next_s.exec     = 1'b0;                            // RULE3
                end
                else
                begin
                    unique case (op)
                        seq_pkg::OP_JUMP:
                        begin
                            next_s.pc   = cmd.target;
                            next_s.exec = 1'b0;                        // RULE3
                        end
                        seq_pkg::OP_CALL:
                        begin
                            next_s      = push(next_s, s.pc);          // RULE17
                            next_s.pc   = cmd.target;
                            next_s.exec = 1'b0;                        // RULE3
                        end
                        seq_pkg::OP_RET, seq_pkg::OP_ISR_EXIT_OP:
                        begin
                            // Pop; an empty stack wraps like the hardware ring
                            ret_pc        = s.stack[2'(s.sp_wr - 2'h1)];
                            next_s.pc     = ret_pc;                    // RULE17
                            next_s.sp_wr  = s.sp_wr - 2'h1;
                            if (s.depth != 3'h0)
                                next_s.depth = s.depth - 3'h1;
                            next_s.exec      = 1'b0;                   // RULE3
                            next_s.isr_exit_op_done = (op == seq_pkg::OP_ISR_EXIT_OP);
                        end
                        seq_pkg::OP_SKIP:
                            next_s.exec = 1'b0;                        // RULE5
                        seq_pkg::OP_TAB_CUR:
                        begin
                            next_s.tab_busy = 1'b1;                    // RULE15
                            next_s.tab_dest = cmd.dest;
                            next_s.exec     = 1'b0;
                        end
                        seq_pkg::OP_TAB_LAST:
                        begin
                            next_s.tab_busy = 1'b1;                    // RULE15
                            next_s.tab_dest = cmd.dest;
                            next_s.exec     = 1'b0;
                        end
                        seq_pkg::OP_NONE:
                        begin
                            // Interrupts only while the stack has room
                            if (s.depth != seq_pkg::STACK_FULL)        // RULE19
                            begin
                                if (ext_irq)
                                begin
                                    next_s         = push(next_s, s.pc);
                                    next_s.pc      = seq_pkg::EXT_VEC; // RULE8
                                    next_s.exec    = 1'b0;
                                    next_s.ext_ack = 1'b1;
                                end
                                else if (tmr_irq)
                                begin
                                    next_s         = push(next_s, s.pc);
                                    next_s.pc      = seq_pkg::TMR_VEC; // RULE9
                                    next_s.exec    = 1'b0;
                                    next_s.tmr_ack = 1'b1;
                                end
                            end
                        end
                    endcase
                end

                // Address for the coming cycle: table word or next fetch
                // A low byte write landing on this edge cancels the table read
                if (next_s.tab_busy && op == seq_pkg::OP_TAB_CUR)
                    next_s.rom_addr = {s.pc[10:8], s.tblptr};          // RULE11
                else if (next_s.tab_busy && op == seq_pkg::OP_TAB_LAST)
                    next_s.rom_addr = {seq_pkg::LAST_PAGE, s.tblptr};  // RULE12
                else
                    next_s.rom_addr = next_s.pc;                       // RULE10
                if (next_s.tab_busy)
                    next_s.pc = s.pc + 11'h001;                        // RULE4
            end
        end
    end

    // State register
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            s          <= '0;
            s.pc       <= seq_pkg::RESET_VEC;                          // RULE7
            s.rom_addr <= seq_pkg::RESET_VEC;                          // RULE7
            s.depth    <= 3'h0;                                        // RULE18
        end
        else
        begin
            s <= next_s;
        end
    end

    // Outputs straight from state
    assign reg_rdata  = s.rdata;
    assign rom_addr   = s.rom_addr;
    assign ext_ack    = s.ext_ack;
    assign tmr_ack    = s.tmr_ack;
    assign isr_exit_op_done  = s.isr_exit_op_done;
    assign instr_word = s.instr;
    assign instr_exec = s.exec;
    assign phase      = s.phase;
    assign fetch_pc   = s.pc;

endmodule

`default_nettype wire

// file: seq_pkg.sv
package seq_pkg;

    // Program memory geometry
    localparam int unsigned PC_W       = 11;
    localparam int unsigned ROM_W      = 14;
    localparam int unsigned ROM_DEPTH  = 2048;
    localparam int unsigned PAGE_W     = 8;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned TAB_HI_W   = ROM_W - DATA_W;

    // Instruction cycle phases
    localparam int unsigned PHASES     = 4;
    localparam logic [1:0]  PHASE_LAST = 2'h3;

    // Return stack geometry
    localparam int unsigned STACK_DEPTH = 4;
    localparam logic [2:0]  STACK_FULL  = 3'h4;

    // Fixed program addresses
    localparam logic [10:0] RESET_VEC = 11'h000;
    localparam logic [10:0] EXT_VEC   = 11'h004;
    localparam logic [10:0] TMR_VEC   = 11'h008;
    localparam logic [2:0]  LAST_PAGE = 3'h7;

    // Data memory map
    localparam logic [7:0] ADDR_INDIRECT = 8'h00;
    localparam logic [7:0] ADDR_DPTR     = 8'h01;
    localparam logic [7:0] ADDR_PCL      = 8'h06;
    localparam logic [7:0] ADDR_TBLPTR   = 8'h07;
    localparam logic [7:0] ADDR_TBLHI    = 8'h08;
    localparam logic [7:0] ADDR_RAM_LO   = 8'h20;
    localparam logic [7:0] ADDR_RAM_HI   = 8'h7F;
    localparam int unsigned RAM_WORDS    = 96;
    localparam logic [7:0] ZERO_BYTE     = 8'h00;

    // Sequencing commands from the instruction decoder
    typedef enum logic [2:0] {
        OP_NONE     = 3'b000,
        OP_JUMP     = 3'b001,
        OP_CALL     = 3'b010,
        OP_RET      = 3'b011,
        OP_ISR_EXIT_OP     = 3'b100,
        OP_SKIP     = 3'b101,
        OP_TAB_CUR  = 3'b110,
        OP_TAB_LAST = 3'b111
    } seq_op_t;

    // Command bundle, sampled in the last phase of an executing cycle
    typedef struct packed {
        seq_op_t     op;
        logic [10:0] target;
        logic [7:0]  dest;
    } seq_cmd_t;

    // Register bus request bundle
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_t;

endpackage

// file: seq_rom_model.sv
`timescale 1ns/1ps
`default_nettype none
// Program memory stand-in: each word encodes its own address
module seq_rom_model
(
    input  wire logic [10:0] rom_addr,  // Word address
    output logic      [13:0] rom_data   // Word at that address
);
    // Page bits appear twice so page errors show in the high part
    always_comb
    begin
        rom_data = {rom_addr[10:8] ^ 3'h5, rom_addr[10:8], rom_addr[7:0]};
    end
endmodule
`default_nettype wire

// file: seq_chk.sv
`timescale 1ns/1ps
`default_nettype none
// Watches sequencing at the block's ports
module seq_chk
(
    input wire logic              sys_clk,
    input wire logic              sys_rst,
    input wire seq_pkg::reg_req_t reg_req,
    input wire logic [10:0]       rom_addr,
    input wire logic [13:0]       rom_data,
    input wire seq_pkg::seq_cmd_t cmd,
    input wire logic              ext_irq,
    input wire logic              tmr_irq,
    input wire logic              ext_ack,
    input wire logic              tmr_ack,
    input wire logic [13:0]       instr_word,
    input wire logic              instr_exec,
    input wire logic [1:0]        phase,
    input wire logic [10:0]       fetch_pc
);
    logic       pend;  // Low byte write not yet applied
    logic [7:0] tptr;  // Copy of the lookup pointer
    logic       wpcl;  // Low byte write this cycle
    logic [2:0] page;  // Page of the counter
    assign wpcl = reg_req.wr && reg_req.addr == seq_pkg::ADDR_PCL;
    assign page = fetch_pc[10:8];
    // Pending in-page jumps hide commands; keep the pointer copy
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pend <= 1'b0;
            tptr <= 8'h00;
        end
        else
        begin
            pend <= wpcl || (pend && phase != seq_pkg::PHASE_LAST);
            if (reg_req.wr && reg_req.addr == seq_pkg::ADDR_TBLPTR)
                tptr <= reg_req.wdata;
        end
    end
    default clocking dc @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    // Boundary edge that takes a real command
    sequence s_take(seq_pkg::seq_op_t o);
        phase == seq_pkg::PHASE_LAST && instr_exec && cmd.op == o && !pend && !wpcl;
    endsequence
    a_phase_wrap: assert property (1'b1 |=> phase == $past(phase) + 2'h1)
        else $error("phase count broken");
    a_cycle_hold: assert property (
        phase != seq_pkg::PHASE_LAST |=> $stable(rom_addr) && $stable(instr_exec))
        else $error("fetch changed inside a cycle");
    a_word_latch: assert property (
        phase == seq_pkg::PHASE_LAST && instr_exec |=> instr_word == $past(rom_data))
        else $error("fetched word not latched");
    a_pc_step: assert property (
        s_take(seq_pkg::OP_NONE) ##0 !ext_irq && !tmr_irq
        |=> fetch_pc == $past(fetch_pc) + 11'h1 && instr_exec)
        else $error("counter did not step by one");
    a_branch_load: assert property (
        s_take(seq_pkg::OP_JUMP) or s_take(seq_pkg::OP_CALL)
        |=> fetch_pc == $past(cmd.target) && !instr_exec)
        else $error("branch target or dummy wrong");
    a_skip_dummy: assert property (
        s_take(seq_pkg::OP_SKIP) |=> !instr_exec && fetch_pc == $past(fetch_pc) + 11'h1)
        else $error("skip did not discard");
    a_last_page: assert property (
        s_take(seq_pkg::OP_TAB_LAST) |=> rom_addr == {seq_pkg::LAST_PAGE, tptr} && !instr_exec)
        else $error("last page address wrong");
    a_cur_page: assert property (
        s_take(seq_pkg::OP_TAB_CUR) |=> rom_addr == {$past(page), tptr} && !instr_exec)
        else $error("current page address wrong");
    a_ext_vector: assert property (
        ext_ack |-> fetch_pc == seq_pkg::EXT_VEC && phase == 2'h0 ##1 !ext_ack)
        else $error("external vector wrong");
    a_tmr_vector: assert property (
        tmr_ack |-> fetch_pc == seq_pkg::TMR_VEC && !ext_ack && !instr_exec)
        else $error("timer vector wrong");
endmodule
bind program_sequencer seq_chk u_chk (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req),
    .rom_addr(rom_addr), .rom_data(rom_data), .cmd(cmd), .ext_irq(ext_irq),
    .tmr_irq(tmr_irq), .ext_ack(ext_ack), .tmr_ack(tmr_ack), .instr_word(instr_word),
    .instr_exec(instr_exec), .phase(phase), .fetch_pc(fetch_pc));
`default_nettype wire

// file: tb.sv
`timescale 1ns/1ps
`default_nettype none
// Drives bus and decoder commands, compares against expectations
module tb;
    logic              sys_clk;
    logic              sys_rst;
    seq_pkg::reg_req_t reg_req;
    seq_pkg::seq_cmd_t cmd;
    logic              ext_irq;
    logic              tmr_irq;
    logic              ext_ack;
    logic              tmr_ack;
    logic              isr_exit_op_done;
    logic              instr_exec;
    logic [7:0]        reg_rdata;
    logic [10:0]       rom_addr;
    logic [10:0]       fetch_pc;
    logic [10:0]       prev_pc;      // Counter in the commanding cycle
    logic [10:0]       ret_pc;       // Return address of an interrupt
    logic [13:0]       rom_data;
    logic [13:0]       instr_word;
    logic [1:0]        phase;
    logic [10:0]       stk[$];       // Expected return stack
    int                n_fail = 0;
    int                checks_done = 0;
    int                cycles = 0;
    int                hits;
    program_sequencer DUT (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .rom_addr(rom_addr), .rom_data(rom_data), .cmd(cmd),
        .ext_irq(ext_irq), .tmr_irq(tmr_irq), .ext_ack(ext_ack), .tmr_ack(tmr_ack),
        .isr_exit_op_done(isr_exit_op_done), .instr_word(instr_word), .instr_exec(instr_exec), .phase(phase),
        .fetch_pc(fetch_pc));
    seq_rom_model rom (.rom_addr(rom_addr), .rom_data(rom_data));
    // Clock and hang guard
    initial
    begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_fail++;
            give_verdict();
        end
    end
    // Expected word held at a program address
    function automatic logic [13:0] word_at(input logic [10:0] a);
        return {a[10:8] ^ 3'h5, a[10:8], a[7:0]};
    endfunction
    task automatic check(input string nm, input logic [13:0] seen, input logic [13:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic give_verdict();
        if (n_fail == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask
    // Read data is looked at in the one cycle it stands
    task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        @(posedge sys_clk);
        reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        @(negedge sys_clk);
        check(nm, {6'h00, reg_rdata}, {6'h00, exp});
    endtask
    // Command rides the boundary edge of a real instruction cycle
    task automatic issue(input seq_pkg::seq_op_t op, input logic [10:0] tgt);
        int i;
        i = 0;
        @(negedge sys_clk);
        while (!(phase === 2'h2 && instr_exec === 1'b1) && i < 40)
        begin
            @(negedge sys_clk);
            i++;
        end
        if (i >= 40)
            n_fail++;
        prev_pc = fetch_pc;
        @(posedge sys_clk);
        cmd <= '{op: op, target: tgt, dest: 8'h40 + 8'(op)};
        @(posedge sys_clk);
        cmd.op <= seq_pkg::OP_NONE;
        @(negedge sys_clk);
    endtask
    // Waits for an acknowledge, noting the counter just before it
    task automatic await_ack(input bit tmr);
        int i;
        i = 0;
        while ((tmr ? tmr_ack : ext_ack) !== 1'b1 && i < 40)
        begin
            ret_pc = fetch_pc;
            @(negedge sys_clk);
            i++;
        end
        check("vector", fetch_pc, tmr ? seq_pkg::TMR_VEC : seq_pkg::EXT_VEC);
        stk.push_back(ret_pc);
    endtask
    initial
    begin
        reg_req = '0;
        cmd = '0;
        ext_irq = 1'b0;
        tmr_irq = 1'b0;
        sys_rst = 1'b1;
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        @(negedge sys_clk);
        check("reset pc", fetch_pc, 14'h0000);
        bus_wr(8'h21, 8'h5A);
        bus_rd(8'h21, 8'h5A, "ram low");
        bus_wr(8'h7F, 8'hC3);
        bus_rd(8'h7F, 8'hC3, "ram top");
        bus_wr(8'h10, 8'hFF);
        bus_rd(8'h10, 8'h00, "empty loc");
        bus_wr(8'h01, 8'h30);
        bus_wr(8'h00, 8'hA5);
        bus_rd(8'h30, 8'hA5, "indirect wr");
        bus_wr(8'h01, 8'h00);
        bus_rd(8'h00, 8'h00, "slot itself");
        bus_wr(8'h08, 8'h3F);
        bus_rd(8'h08, 8'h00, "high ro");
        bus_wr(8'h07, 8'h44);
        bus_rd(8'h07, 8'h44, "pointer");
        // Table reads on the last page, then the current page
        issue(seq_pkg::OP_TAB_LAST, 11'h000);
        check("tab dummy", instr_exec, 14'h0000);
        repeat (4) @(negedge sys_clk);
        check("tab exec", instr_exec, 14'h0001);
        bus_rd(8'h47, 8'h44, "last low");
        bus_rd(8'h08, 8'h17, "last high");
        bus_wr(8'h07, 8'h9C);
        issue(seq_pkg::OP_TAB_CUR, 11'h000);
        check("cur addr", rom_addr, {prev_pc[10:8], 8'h9C});
        repeat (4) @(negedge sys_clk);
        bus_rd(8'h46, 8'h9C, "cur low");
        bus_rd(8'h08, {2'h0, prev_pc[10:8] ^ 3'h5, prev_pc[10:8]}, "cur high");
        // Jump, then a met skip
        issue(seq_pkg::OP_JUMP, 11'h123);
        check("jump pc", fetch_pc, 14'h0123);
        repeat (4) @(negedge sys_clk);
        check("jump word", instr_word, word_at(11'h123));
        issue(seq_pkg::OP_SKIP, 11'h000);
        check("skip dummy", instr_exec, 14'h0000);
        repeat (4) @(negedge sys_clk);
        check("skip word", instr_word, word_at(prev_pc + 11'h1));
        bus_wr(8'h06, 8'h50);
        for (int i = 0; i < 12 && instr_exec !== 1'b0; i++)
            @(negedge sys_clk);
        check("pcl jump", fetch_pc, 14'h0150);
        bus_rd(8'h06, 8'h50, "pcl read");
        // Five calls into four levels: oldest lost
        for (int k = 0; k < 5; k++)
        begin
            issue(seq_pkg::OP_CALL, 11'h200 + 11'(k * 16));
            stk.push_back(prev_pc);
            if (stk.size() > 4)
                void'(stk.pop_front());
        end
        @(posedge sys_clk);
        ext_irq <= 1'b1;
        hits = 0;
        repeat (16)
        begin
            @(negedge sys_clk);
            hits += int'(ext_ack === 1'b1);
        end
        check("full ack", 14'(hits), 14'h0000);
        issue(seq_pkg::OP_RET, 11'h000);
        check("ret pc", fetch_pc, stk.pop_back());
        check("ret pulse", isr_exit_op_done, 14'h0000);
        await_ack(1'b0);
        @(posedge sys_clk);
        ext_irq <= 1'b0;
        tmr_irq <= 1'b1;
        issue(seq_pkg::OP_ISR_EXIT_OP, 11'h000);
        check("isr_exit_op pc", fetch_pc, stk.pop_back());
        check("isr_exit_op pulse", isr_exit_op_done, 14'h0001);
        await_ack(1'b1);
        @(posedge sys_clk);
        tmr_irq <= 1'b0;
        while (stk.size() > 0)
        begin
            issue(seq_pkg::OP_RET, 11'h000);
            check("unwind pc", fetch_pc, stk.pop_back());
        end
        give_verdict();
    end
endmodule
`default_nettype wire
